// ### hdl/lcdi2_pkg.sv
package lcdi2_pkg;
  // bus address of this port, value arbitrary
  localparam logic [6:0] BUS_ADDR      = 7'h2c;
  // command opcodes, values arbitrary except soft reset
  localparam logic [7:0] CMD_SOFT_RST  = 8'haa;
  localparam logic [7:0] CMD_DISP_DATA = 8'h80;
  localparam logic [7:0] CMD_DRIVE     = 8'h82;
  localparam logic [7:0] CMD_SYS       = 8'h84;
  localparam logic [7:0] CMD_FRAME     = 8'h86;
  localparam logic [7:0] CMD_BLINK     = 8'h88;
  localparam logic [7:0] CMD_LED       = 8'h8a;
  // setting byte fields
  localparam int SYS_OSC_BIT  = 1;
  localparam int SYS_DISP_BIT = 0;
  // top ram address per drive mode
  localparam logic [3:0] TOP_32 = 4'hf;
  localparam logic [3:0] TOP_28 = 4'hd;
  localparam logic [3:0] TOP_24 = 4'hb;
  // led roles of the shared pins, led7 on the lowest shared pin
  localparam logic [7:0] LED_MASK_28 = 8'h0f;
  localparam logic [7:0] LED_MASK_24 = 8'hff;
  localparam int SHARED_LSB = 24;
  // reset values
  localparam logic [1:0] SEL_RST   = 2'h0;
  localparam logic [1:0] FRAME_RST = 2'h0;
  localparam logic [1:0] BLINK_RST = 2'h0;
  // sizes
  localparam int RAM_WORDS  = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int TICK_W     = 22;
  // timing: 10 MHz core clock
  localparam int CLK_HZ = 10_000_000;
  // frame rates in tenths of hertz
  localparam int FRAME_DHZ_0 = 640;
  localparam int FRAME_DHZ_1 = 853;
  localparam int FRAME_DHZ_2 = 1280;
  localparam int FRAME_DHZ_3 = 1706;
  // one common phase is a quarter frame
  localparam int PHASE_CYC_0 = CLK_HZ * 10 / (FRAME_DHZ_0 * 4);
  localparam int PHASE_CYC_1 = CLK_HZ * 10 / (FRAME_DHZ_1 * 4);
  localparam int PHASE_CYC_2 = CLK_HZ * 10 / (FRAME_DHZ_2 * 4);
  localparam int PHASE_CYC_3 = CLK_HZ * 10 / (FRAME_DHZ_3 * 4);
  // blink base step is half of the fastest blink period
  localparam int BLINK_STEP_MS  = 250;
  localparam int BLINK_STEP_CYC = CLK_HZ / 1000 * BLINK_STEP_MS;

  typedef enum logic [2:0] {
    I_IDLE  = 3'b000,
    I_ADDR  = 3'b001,
    I_ACKA  = 3'b010,
    I_RX    = 3'b011,
    I_ACKR  = 3'b100,
    I_TX    = 3'b101,
    I_TXACK = 3'b110
  } lcdi2_i2c_e;

  typedef enum logic [1:0] {
    P_IGN   = 2'b00,
    P_SET   = 2'b01,
    P_RADDR = 2'b10,
    P_DATA  = 2'b11
  } lcdi2_proc_e;

  // one received byte, marked when it opens a command
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } lcdi2_word_s;
endpackage

// ### hdl/lcdi2_fifo.sv
`timescale 1ns/1ns
module lcdi2_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and control
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // power of two keeps pointer wrap free
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage words
    logic [AW-1:0]               wr;   // write index
    logic [AW-1:0]               rd;   // read index
    logic [AW:0]                 cnt;  // fill level
  } lcdi2_fifo_s;

  lcdi2_fifo_s st_r;
  lcdi2_fifo_s st_nxt;
  logic        push;
  logic        pop;

  assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = st_r.mem[st_r.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // next state: write, read, level
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr           = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ### hdl/lcdi2_tick.sv
`timescale 1ns/1ns
module lcdi2_tick #(
  parameter int CW = 22
) (
  // clock and control
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  // divider
  input  wire logic          run_i,
  input  wire logic [CW-1:0] limit_i,
  output logic               tick_o
);
  typedef struct packed {
    logic [CW-1:0] cnt;   // cycles into the period
    logic          tick;  // one-cycle pulse per period
  } lcdi2_tick_s;

  lcdi2_tick_s st_r;
  lcdi2_tick_s st_nxt;

  assign tick_o = st_r.tick;

  // held at zero while stopped, so a restart is a full period
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= limit_i - 1'b1) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ### hdl/lcdi2_top.sv
`timescale 1ns/1ns
// Functional notes
// - sda falling, scl high, starts address
// - sda rising, scl high, ends transfer
// - repeated start acts as fresh start
// - sda changes only while scl low
// - bytes eight bits, msb first, ack
// - ack holds sda low whole ack high
// - first byte: address plus direction bit
// - acknowledge only on own address match
// - ram write: command, address, data
// - store at pointer, then advance
// - pointer wraps after mode top address
// - read advance only after acked byte
// - reads continue until master nacks
// - blink modes off, 2, 1, 0.5 hz
// - four frame rates by frame command
// - led bits msb first, one lights
// - select bits give shared pins role
// - 32, 28 or 24 segments, four commons
// - select: 32, 28 plus 4, 24 plus 8
// - ram one lights, columns map commons
// - reset: 64 hz, no blink, off
module lcdi2_top
  import lcdi2_pkg::*;
#(
  parameter int PHASE0 = lcdi2_pkg::PHASE_CYC_0,
  parameter int PHASE1 = lcdi2_pkg::PHASE_CYC_1,
  parameter int PHASE2 = lcdi2_pkg::PHASE_CYC_2,
  parameter int PHASE3 = lcdi2_pkg::PHASE_CYC_3,
  parameter int BLINK_STEP = lcdi2_pkg::BLINK_STEP_CYC
) (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // two-wire bus, data pin open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oen_o,
  // display pins
  output logic [31:0]      segment_outputs_o,
  output logic [3:0]       common_outputs_o,
  output logic [7:0]       led_outputs_o,
  // status
  output logic             display_on_o,
  output logic             osc_on_o
);
  import lcdi2_pkg::*;

  // dividers must fit the tick counter
  if (PHASE0 < 1 || PHASE1 < 1 || PHASE2 < 1 || PHASE3 < 1 ||
      BLINK_STEP < 1 || BLINK_STEP >= (1 << TICK_W) ||
      PHASE0 >= (1 << TICK_W)) begin : g_bad_div
    $error("divider counts out of range");
  end

  typedef struct packed {
    lcdi2_i2c_e                      i2c;     // bus state
    logic [3:0]                      bitcnt;  // bits in current byte
    logic [7:0]                      shreg;   // shift register
    logic                            rw;      // direction of transfer
    logic                            first;   // next byte opens command
    logic                            mack;    // master acked last byte
    logic                            scl_q;   // previous scl sample
    logic                            sda_q;   // previous sda sample
    logic                            oen;     // low while pulling sda
    logic                            push;    // fifo write strobe
    lcdi2_word_s                     pword;   // word to push
    lcdi2_proc_e                     proc;    // command decoder
    logic [7:0]                      pcmd;    // pending compound cmd
    logic [3:0]                      ptr;     // address pointer
    logic [RAM_WORDS-1:0][7:0]       ram;     // display ram
    logic [1:0]                      sel;     // shared pin select
    logic [1:0]                      frame;   // frame rate code
    logic [1:0]                      blink;   // blink mode
    logic                            osc;     // oscillator on
    logic                            disp;    // display on
    logic [7:0]                      led;     // led data
    logic [1:0]                      phase;   // active common
    logic [1:0]                      bstep;   // blink step count
    logic                            blank;   // blink off half
    logic [31:0]                     seg;     // segment pins
    logic [3:0]                      com;     // common pins
    logic [7:0]                      leds;    // led pins
  } lcdi2_st_s;

  lcdi2_st_s      st_r;
  lcdi2_st_s      st_nxt;
  logic           start_w;   // start or repeated start
  logic           stop_w;    // stop condition
  logic           rise_w;    // scl rising
  logic           fall_w;    // scl falling
  logic           in_ready;  // fifo has room
  logic           out_valid; // fifo holds a byte
  logic           drain_rdy; // decoder may take a byte
  lcdi2_word_s    out_word;  // byte at fifo head
  logic           pop_w;     // byte taken this cycle
  logic           ph_tick;   // common phase step
  logic           bl_tick;   // blink step
  logic [TICK_W-1:0] ph_lim; // phase divider for frame rate

  // top address of the ram for a drive mode
  function automatic logic [3:0] top_addr(input logic [1:0] s);
    if (!s[1]) begin
      return TOP_32;
    end
    return s[0] ? TOP_24 : TOP_28;
  endfunction

  // pointer advance with wrap, also fixes a stale pointer
  function automatic logic [3:0] next_ptr(input logic [3:0] p,
                                          input logic [1:0] s);
    return (p >= top_addr(s)) ? 4'h0 : p + 4'h1;
  endfunction

  // shared pins acting as leds
  function automatic logic [7:0] led_mask(input logic [1:0] s);
    if (!s[1]) begin
      return 8'h00;
    end
    return s[0] ? LED_MASK_24 : LED_MASK_28;
  endfunction

  // bus conditions from synchronous samples
  assign rise_w  = scl_i && !st_r.scl_q;
  assign fall_w  = !scl_i && st_r.scl_q;
  assign start_w = scl_i && st_r.scl_q && st_r.sda_q && !sda_i;
  assign stop_w  = scl_i && st_r.scl_q && !st_r.sda_q && sda_i;

  // decoder waits while a read is in flight, so pointer has one user
  assign drain_rdy = (st_r.i2c != I_TX) && (st_r.i2c != I_TXACK);
  assign pop_w     = out_valid && drain_rdy;

  // received bytes wait here for the decoder
  lcdi2_fifo #(
    .WIDTH ($bits(lcdi2_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .in_valid_i  (st_r.push),
    .in_ready_o  (in_ready),
    .in_data_i   (st_r.pword),
    .out_valid_o (out_valid),
    .out_ready_i (drain_rdy),
    .out_data_o  (out_word)
  );

  // frame rate picks the phase divider
  always_comb begin
    unique case (st_r.frame)
      2'd0: ph_lim = TICK_W'(PHASE0);
      2'd1: ph_lim = TICK_W'(PHASE1);
      2'd2: ph_lim = TICK_W'(PHASE2);
      2'd3: ph_lim = TICK_W'(PHASE3);
    endcase
  end

  lcdi2_tick #(
    .CW (TICK_W)
  ) u_phase (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .run_i      (st_r.osc),
    .limit_i    (ph_lim),
    .tick_o     (ph_tick)
  );

  lcdi2_tick #(
    .CW (TICK_W)
  ) u_blink (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .run_i      (st_r.osc && st_r.blink != 2'd0),
    .limit_i    (TICK_W'(BLINK_STEP)),
    .tick_o     (bl_tick)
  );

  // whole next state: bus, decoder, display
  always_comb begin
    logic       on;
    logic [7:0] lm;  // led role of each shared pin
    on            = 1'b0;
    lm            = 8'h00;
    st_nxt        = st_r;
    st_nxt.scl_q  = scl_i;
    st_nxt.sda_q  = sda_i;
    st_nxt.push   = 1'b0;
    // bus side
    if (start_w) begin
      st_nxt.i2c    = I_ADDR;
      st_nxt.bitcnt = 4'd0;
      st_nxt.oen    = 1'b1;
    end else if (stop_w) begin
      st_nxt.i2c = I_IDLE;
      st_nxt.oen = 1'b1;
    end else begin
      unique case (st_r.i2c)
        I_IDLE: begin
          st_nxt.oen = 1'b1;
        end
        I_ADDR, I_RX: begin
          if (rise_w) begin
            st_nxt.shreg  = {st_r.shreg[6:0], sda_i};
            st_nxt.bitcnt = st_r.bitcnt + 4'd1;
          end
          if (fall_w && st_r.bitcnt == 4'd8) begin
            if (st_r.i2c == I_ADDR) begin
              if (st_r.shreg[7:1] == BUS_ADDR) begin
                st_nxt.rw  = st_r.shreg[0];
                st_nxt.oen = 1'b0;
                st_nxt.i2c = I_ACKA;
              end else begin
                st_nxt.i2c = I_IDLE;
              end
            end else if (in_ready && !st_r.push) begin
              // full fifo answers with no ack
              st_nxt.push  = 1'b1;
              st_nxt.pword = '{first: st_r.first, data: st_r.shreg};
              st_nxt.first = 1'b0;
              st_nxt.oen   = 1'b0;
              st_nxt.i2c   = I_ACKR;
            end else begin
              st_nxt.i2c = I_IDLE;
            end
          end
        end
        I_ACKA: begin
          if (fall_w) begin
            if (st_r.rw) begin
              st_nxt.shreg  = st_r.ram[st_r.ptr];
              st_nxt.oen    = st_r.ram[st_r.ptr][7];
              st_nxt.bitcnt = 4'd1;
              st_nxt.i2c    = I_TX;
            end else begin
              st_nxt.oen    = 1'b1;
              st_nxt.bitcnt = 4'd0;
              st_nxt.first  = 1'b1;
              st_nxt.i2c    = I_RX;
            end
          end
        end
        I_ACKR: begin
          if (fall_w) begin
            st_nxt.oen    = 1'b1;
            st_nxt.bitcnt = 4'd0;
            st_nxt.i2c    = I_RX;
          end
        end
        I_TX: begin
          if (fall_w) begin
            if (st_r.bitcnt == 4'd8) begin
              st_nxt.oen = 1'b1;
              st_nxt.i2c = I_TXACK;
            end else begin
              st_nxt.oen    = st_r.shreg[6];
              st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
              st_nxt.bitcnt = st_r.bitcnt + 4'd1;
            end
          end
        end
        I_TXACK: begin
          if (rise_w) begin
            st_nxt.mack = !sda_i;
            if (!sda_i) begin
              st_nxt.ptr = next_ptr(st_r.ptr, st_r.sel);
            end
          end
          if (fall_w) begin
            if (st_r.mack) begin
              st_nxt.shreg  = st_r.ram[st_r.ptr];
              st_nxt.oen    = st_r.ram[st_r.ptr][7];
              st_nxt.bitcnt = 4'd1;
              st_nxt.i2c    = I_TX;
            end else begin
              st_nxt.i2c = I_IDLE;
            end
          end
        end
        default: begin
          st_nxt.i2c = I_IDLE;
          st_nxt.oen = 1'b1;
        end
      endcase
    end
    // command decoder
    if (pop_w) begin
      if (out_word.first) begin
        st_nxt.pcmd = out_word.data;
        if (out_word.data == CMD_SOFT_RST) begin
          st_nxt.sel   = SEL_RST;
          st_nxt.frame = FRAME_RST;
          st_nxt.blink = BLINK_RST;
          st_nxt.osc   = 1'b0;
          st_nxt.disp  = 1'b0;
          st_nxt.led   = 8'h00;
          st_nxt.ptr   = 4'h0;
          st_nxt.proc  = P_IGN;
        end else if (out_word.data == CMD_DISP_DATA) begin
          st_nxt.proc = P_RADDR;
        end else if (out_word.data == CMD_DRIVE ||
                     out_word.data == CMD_SYS ||
                     out_word.data == CMD_FRAME ||
                     out_word.data == CMD_BLINK ||
                     out_word.data == CMD_LED) begin
          st_nxt.proc = P_SET;
        end else begin
          st_nxt.proc = P_IGN;
        end
      end else begin
        unique case (st_r.proc)
          P_IGN: begin
            st_nxt.proc = P_IGN;
          end
          P_SET: begin
            st_nxt.proc = P_IGN;
            if (st_r.pcmd == CMD_DRIVE) begin
              st_nxt.sel = out_word.data[1:0];
            end else if (st_r.pcmd == CMD_SYS) begin
              st_nxt.osc  = out_word.data[SYS_OSC_BIT];
              st_nxt.disp = out_word.data[SYS_DISP_BIT];
            end else if (st_r.pcmd == CMD_FRAME) begin
              st_nxt.frame = out_word.data[1:0];
            end else if (st_r.pcmd == CMD_BLINK) begin
              st_nxt.blink = out_word.data[1:0];
            end else begin
              st_nxt.led = out_word.data;
            end
          end
          P_RADDR: begin
            // an address past the top starts at zero
            st_nxt.ptr  = (out_word.data > {4'h0, top_addr(st_r.sel)}) ?
                          4'h0 : out_word.data[3:0];
            st_nxt.proc = P_DATA;
          end
          P_DATA: begin
            st_nxt.ram[st_r.ptr] = out_word.data;
            st_nxt.ptr = next_ptr(st_r.ptr, st_r.sel);
          end
        endcase
      end
    end
    // common phase and blink
    if (ph_tick) begin
      st_nxt.phase = st_r.phase + 2'd1;
    end
    if (st_r.blink == 2'd0) begin
      st_nxt.bstep = 2'd0;
      st_nxt.blank = 1'b0;
    end else if (bl_tick) begin
      st_nxt.bstep = st_r.bstep + 2'd1;
      // toggle every 1, 2 or 4 steps keeps halves equal
      if (st_r.blink == 2'd1 ||
          (st_r.blink == 2'd2 && st_r.bstep[0]) ||
          (st_r.blink == 2'd3 && st_r.bstep == 2'd3)) begin
        st_nxt.blank = !st_r.blank;
      end
    end
    // pin levels, registered for clean outputs
    on         = st_r.disp && st_r.osc && !st_r.blank;
    st_nxt.seg = '0;
    st_nxt.com = '0;
    if (on) begin
      st_nxt.com[st_r.phase] = 1'b1;
      for (int i = 0; i < RAM_WORDS; i++) begin
        st_nxt.seg[2*i]   = st_r.ram[i][st_r.phase];
        st_nxt.seg[2*i+1] = st_r.ram[i][3'd4 + st_r.phase];
      end
    end
    lm = led_mask(st_r.sel);
    for (int k = 0; k < 8; k++) begin
      if (lm[7-k]) begin
        st_nxt.seg[SHARED_LSB+k] = 1'b0;
      end
    end
    st_nxt.leds = st_r.led & led_mask(st_r.sel);
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r       <= '0;
      st_r.oen   <= 1'b1;
      st_r.scl_q <= 1'b1;
      st_r.sda_q <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign sda_o             = 1'b0;
  assign sda_oen_o         = st_r.oen;
  assign segment_outputs_o = st_r.seg;
  assign common_outputs_o  = st_r.com;
  assign led_outputs_o     = st_r.leds;
  assign display_on_o      = st_r.disp;
  assign osc_on_o          = st_r.osc;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_start;
    ce_i && start_w |=> st_r.i2c == I_ADDR && st_r.bitcnt == 4'd0;
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  property p_restart;
    ce_i && start_w && st_r.i2c != I_IDLE |=> st_r.i2c == I_ADDR && sda_oen_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");

  property p_stop;
    ce_i && stop_w |=> st_r.i2c == I_IDLE && sda_oen_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");

  property p_ack;
    st_r.i2c == I_ACKR |-> !sda_oen_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not driven");

  property p_release;
    st_r.i2c inside {I_IDLE, I_ADDR, I_RX, I_TXACK} |-> sda_oen_o;
  endproperty
  a_release: assert property (p_release) else $error("sda held");

  property p_change;
    $changed(sda_oen_o) |->
      !$past(scl_i) || $past(start_w) || $past(stop_w);
  endproperty
  a_change: assert property (p_change) else $error("sda moved");

  property p_nomatch;
    ce_i && st_r.i2c == I_ADDR && fall_w && st_r.bitcnt == 4'd8 &&
      st_r.shreg[7:1] != BUS_ADDR |=> st_r.i2c == I_IDLE && sda_oen_o;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("bad ack");

  property p_rdinc;
    ce_i && st_r.i2c == I_TXACK && rise_w && !sda_i |=>
      st_r.ptr == next_ptr($past(st_r.ptr), $past(st_r.sel));
  endproperty
  a_rdinc: assert property (p_rdinc) else $error("read ptr");

  property p_wr;
    ce_i && pop_w && !out_word.first && st_r.proc == P_DATA |=>
      st_r.ram[$past(st_r.ptr)] == $past(out_word.data) &&
      st_r.ptr == next_ptr($past(st_r.ptr), $past(st_r.sel));
  endproperty
  a_wr: assert property (p_wr) else $error("ram write");

  property p_blink;
    ce_i && bl_tick && st_r.blink == 2'd1 |=> st_r.blank != $past(st_r.blank);
  endproperty
  a_blink: assert property (p_blink) else $error("blink");

  property p_com;
    ce_i |=> $onehot0(common_outputs_o) &&
      (!$past(st_r.blank) || common_outputs_o == 4'h0);
  endproperty
  a_com: assert property (p_com) else $error("commons");

  c_read: cover property (st_r.i2c == I_TXACK && rise_w && !sda_i);
  c_write: cover property (pop_w && st_r.proc == P_DATA);
  c_blink: cover property ($rose(st_r.blank));
  c_full: cover property (!in_ready);
endmodule

// ### sim/lcdi2_master.sv
`timescale 1ns/1ns
// bus master model, moves its lines on falling core edges
module lcdi2_master (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  // four cycles, above the two cycle minimum
  task automatic hp();
    repeat (4) @(negedge core_clk_i);
  endtask
  // data drops while clock high, also as restart
  task automatic start();
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
    hp();
  endtask
  // data rises while clock high
  task automatic stop();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask
  // set while low, sample late in high half
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
    hp();
  endtask
  // msb first, ninth clock reads the ack
  task automatic wr(input logic [7:0] b, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ok = ~r;
  endtask
  // released data, nack only on the last byte
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask
endmodule

// ### sim/lcdi2_top_tb_top.sv
`timescale 1ns/1ns
module lcdi2_top_tb_top;
  import lcdi2_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        scl, msda, sda_d, oen, sda, dsp, osc, ok;
  logic        ce = 1'b1;
  logic [31:0] seg, s;
  logic [3:0]  com, c;
  logic [7:0]  led, b;
  int          mem [16];
  int          tp [3] = '{15, 13, 11};
  // bench phase counts per frame code, slowest rate longest
  int          phs [4] = '{8, 6, 4, 3};
  localparam int BSTEP = 8;
  int          n_mismatch = 0, comparisons = 0, seed = 49473, p, k, j;
  // wire is low if either side pulls
  assign sda = msda & (oen | sda_d);
  initial forever #50 core_clk_i = ~core_clk_i;
  lcdi2_master lcdi2_master_i (.core_clk_i, .sda_i(sda), .scl_o(scl),
    .sda_o(msda));
  lcdi2_top #(.PHASE0(8), .PHASE1(6), .PHASE2(4), .PHASE3(3),
    .BLINK_STEP(BSTEP)) lcdi2_top_i (.core_clk_i, .resetn_i, .ce_i(ce),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oen_o(oen),
    .segment_outputs_o(seg), .common_outputs_o(com), .led_outputs_o(led),
    .display_on_o(dsp), .osc_on_o(osc));
  task automatic check(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // write address, then bytes that must all be acked
  task automatic send(input logic [7:0] q[$], input logic hold);
    logic a;
    lcdi2_master_i.start();
    lcdi2_master_i.wr({BUS_ADDR, 1'b0}, a);
    check(a, 1);
    foreach (q[i]) begin
      lcdi2_master_i.wr(q[i], a);
      check(a, 1);
    end
    if (!hold) lcdi2_master_i.stop();
  endtask
  // model pointer step with wrap at the top
  function automatic int nx(int a, int t);
    return a >= t ? 0 : a + 1;
  endfunction
  // segments under the lit common against the ram model, 24 pin mode
  task automatic seg_chk();
    logic [31:0] e;
    int ph;
    e = '0;
    ph = 0;
    for (int i = 0; i < 4; i++) if (com[i]) ph = i;
    for (int i = 0; i < 12; i++) begin
      e[2*i] = mem[i][ph];
      e[2*i+1] = mem[i][4+ph];
    end
    check(seg, e);
    check($onehot(com), 1);
  endtask
  // a common stays lit for the phase count of the frame code
  task automatic frame(input int f);
    int n;
    send({CMD_FRAME, 8'(f)}, 1'b0);
    c = com;
    while (com === c) @(negedge core_clk_i);
    c = com;
    n = 0;
    while (com === c && n < 50) begin
      n++;
      @(negedge core_clk_i);
    end
    check(n, phs[f]);
    seg_chk();
  endtask
  // length of one blanked run of the commons
  task automatic blank_len(output int n);
    n = 0;
    while (com === 4'h0) @(negedge core_clk_i);
    while (com !== 4'h0) @(negedge core_clk_i);
    while (com === 4'h0 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
  endtask
  // page write across the top, read back after restart
  task automatic page(int a, int n, int t);
    logic [7:0] q[$];
    logic [7:0] v;
    q = {CMD_DISP_DATA, 8'(a)};
    p = a;
    repeat (n) begin
      v = $random(seed);
      q.push_back(v);
      mem[p] = v;
      p = nx(p, t);
    end
    send(q, 1'b0);
    send({CMD_DISP_DATA, 8'(a)}, 1'b1);
    lcdi2_master_i.start();
    lcdi2_master_i.wr({BUS_ADDR, 1'b1}, ok);
    check(ok, 1);
    p = a;
    for (int i = 0; i < n; i++) begin
      lcdi2_master_i.rd(i == n - 1, b);
      check(b, mem[p]);
      p = nx(p, t);
    end
    lcdi2_master_i.stop();
  endtask
  initial begin
    repeat (4) @(negedge core_clk_i);
    resetn_i = 1'b1;
    @(negedge core_clk_i);
    check({oen, dsp, osc, com, led}, 15'h4000);
    check(seg, 0);
    lcdi2_master_i.start();
    lcdi2_master_i.wr({BUS_ADDR ^ 7'h01, 1'b0}, ok);
    check(ok, 0);
    lcdi2_master_i.stop();
    send({CMD_SYS, 8'h03}, 1'b0);
    check({dsp, osc}, 2'h3);
    // drive modes 00, 10, 11 and their tops
    for (int m = 0; m < 3; m++) begin
      send({CMD_DRIVE, 8'(m == 0 ? 0 : m + 1)}, 1'b0);
      page(tp[m] - 1, 3, tp[m]);
    end
    k = $random(seed);
    send({CMD_LED, 8'(k)}, 1'b0);
    check(led, k[7:0]);
    for (int f = 1; f < 5; f++) frame(f % 4);
    // blanked half of each blink period: 1, 2 and 4 steps
    for (int m = 1; m < 4; m++) begin
      send({CMD_BLINK, 8'(m)}, 1'b0);
      blank_len(j);
      check(j, BSTEP << (m - 1));
    end
    send({CMD_BLINK, 8'h00}, 1'b0);
    k = 0;
    repeat (40) begin
      @(negedge core_clk_i);
      if (com === 4'h0) k++;
    end
    check(k, 0);
    // a low enable freezes the commons mid phase
    ce = 1'b0;
    c = com;
    s = seg;
    repeat (20) @(negedge core_clk_i);
    check(com, c);
    check(seg, s);
    ce = 1'b1;
    send({CMD_SOFT_RST}, 1'b0);
    check({dsp, osc, com, led}, 0);
    summarize();
  end
  initial begin
    #3_000_000;
    n_mismatch++;
    summarize();
  end
endmodule
